// File: spis_pkg.sv
/*
  Package for the serial port interrupt status and clear block: register offsets,
  field positions and reset values.
  Assumes a 32-bit APB register bus with byte addresses.
*/
package spis_pkg;
  // ==========================================================================
  // Register map
  localparam logic [11:0] SPIS_OFF_RAW    = 12'h018;
  localparam logic [11:0] SPIS_OFF_MIS    = 12'h01C;
  localparam logic [11:0] SPIS_OFF_ICR    = 12'h020;
  localparam logic [11:0] SPIS_OFF_MASK   = 12'h024;
  // ==========================================================================
  // Field positions
  localparam int          SPIS_BIT_ROR    = 0;
  localparam int          SPIS_BIT_RT     = 1;
  localparam int          SPIS_BIT_RX     = 2;
  localparam int          SPIS_BIT_TX     = 3;
  localparam int          SPIS_NSRC       = 4;
  // ==========================================================================
  // Reset values
  localparam logic [3:0]  SPIS_MASK_RST   = 4'h0;
  localparam logic [1:0]  SPIS_LATCH_RST  = 2'h0;
  localparam logic [31:0] SPIS_RDATA_RST  = 32'h0000_0000;
endpackage

// File: spis_sync.sv
/*
  Two flip-flop level synchroniser, one per bit.
  Assumes inputs come from outside the pclk domain.
*/
`timescale 1ns/100ps
module spis_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } spis_sync_t;

  spis_sync_t r_q;
  spis_sync_t r_d;

  always_comb begin
    r_d    = r_q;
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign q = r_q.s2;
endmodule // spis_sync

// File: spis_irq.sv
/*
  Interrupt status and clear block of a synchronous serial port, APB slave.
  Assumes FIFO level flags and time-out/overrun event pulses come from the
  serial engine, possibly in another domain, and are synchronised here.
*/
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
module spis_irq
  import spis_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial engine sources
  input  wire logic        tx_half_empty,
  input  wire logic        rx_half_full,
  input  wire logic        rx_timeout_evt,
  input  wire logic        rx_overrun_evt,
  // Interrupt
  output logic             irq
);
  // ==========================================================================
  // Synchronisers
  logic [3:0] src_s;

  spis_sync #(.W(4)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({tx_half_empty, rx_half_full, rx_timeout_evt, rx_overrun_evt}),
    .q       (src_s)
  );

  // ==========================================================================
  // State
  typedef struct packed {
    logic [1:0]  ev_prev;
    logic [1:0]  latch;
    logic [3:0]  mask;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic        irq;
  } spis_state_t;

  spis_state_t s_q;
  spis_state_t s_d;

  logic [3:0] raw;
  logic [3:0] mis;
  logic [1:0] ev_rise;
  logic       setup;
  logic       acc;
  logic       wr;
  logic       rd;
  logic [1:0] clr;

  always_comb begin
    s_d     = s_q;
    ev_rise = src_s[1:0] & ~s_q.ev_prev;
    raw     = {src_s[3:2], s_q.latch};
    mis     = raw & s_q.mask;
    setup   = psel && !penable;
    acc     = psel && penable && s_q.ready;
    wr      = acc && pwrite;
    rd      = setup && !pwrite;
    clr     = '0;
    s_d.ev_prev = src_s[1:0];
    s_d.ready   = setup;
    s_d.err     = 1'b0;
    if (rd) begin
      s_d.rdata = SPIS_RDATA_RST;
    end
    // Reads are decoded in setup; writes commit only at the access edge
    if (setup || wr) begin
      case (paddr)
        SPIS_OFF_RAW: begin
          if (rd) begin
            s_d.rdata[3:0] = raw;
          end
        end
        SPIS_OFF_MIS: begin
          if (rd) begin
            s_d.rdata[3:0] = mis;
          end
        end
        SPIS_OFF_ICR: begin
          if (wr) begin
            clr = pwdata[SPIS_BIT_RT:SPIS_BIT_ROR];
          end
        end
        SPIS_OFF_MASK: begin
          if (wr) begin
            s_d.mask = pwdata[3:0];
          end
          if (rd) begin
            s_d.rdata[3:0] = s_q.mask;
          end
        end
        default: begin
          s_d.err = setup;
        end
      endcase
    end
    // Masked status writes fall through with no effect; set wins over clear
    s_d.latch = (s_q.latch & ~clr) | ev_rise;
    s_d.irq   = |(({src_s[3:2], s_d.latch}) & s_d.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q         <= '0;
      s_q.mask    <= SPIS_MASK_RST;
      s_q.latch   <= SPIS_LATCH_RST;
      s_q.rdata   <= SPIS_RDATA_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata  = s_q.rdata;
  assign pready  = s_q.ready;
  assign pslverr = s_q.err;
  assign irq     = s_q.irq;

  // ==========================================================================
  // Assertions
  property p_mis_read;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == SPIS_OFF_MIS)
      |=> (prdata[3:0] == $past(mis) && prdata[31:4] == 28'h0000000);
  endproperty
  a_mis_read: assert property (p_mis_read) else $error("masked status read wrong");

  property p_mis_write;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == SPIS_OFF_MIS && ev_rise == 2'h0)
      |=> ($stable(s_q.mask) && s_q.latch == $past(s_q.latch));
  endproperty
  a_mis_write: assert property (p_mis_write) else $error("masked status write had effect");

  property p_clear_one;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == SPIS_OFF_ICR && pwdata[1] && !ev_rise[1])
      |=> !s_q.latch[1];
  endproperty
  a_clear_one: assert property (p_clear_one) else $error("time-out not cleared");

  property p_clear_zero;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == SPIS_OFF_ICR && !pwdata[0] && s_q.latch[0])
      |=> s_q.latch[0];
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("overrun lost on zero write");

  property p_clear_zero_rt;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == SPIS_OFF_ICR && !pwdata[1] && s_q.latch[1])
      |=> s_q.latch[1];
  endproperty
  a_clear_zero_rt: assert property (p_clear_zero_rt) else $error("time-out lost");

  property p_evt_set_ror;
    @(posedge pclk) disable iff (!presetn)
      ev_rise[0] |=> s_q.latch[0];
  endproperty
  a_evt_set_ror: assert property (p_evt_set_ror) else $error("overrun event lost");

  property p_evt_set_rt;
    @(posedge pclk) disable iff (!presetn)
      ev_rise[1] |=> s_q.latch[1];
  endproperty
  a_evt_set_rt: assert property (p_evt_set_rt) else $error("time-out event lost");

  property p_upper_zero;
    @(posedge pclk) disable iff (!presetn)
      pready |-> (prdata[31:4] == 28'h0000000);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");

  property p_mask_hold;
    @(posedge pclk) disable iff (!presetn)
      !(wr && paddr == SPIS_OFF_MASK) |=> $stable(s_q.mask);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask changed without write");

  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");

  property p_mask_and;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> (irq == |({$past(src_s[3:2]), s_q.latch} & s_q.mask));
  endproperty
  a_mask_and: assert property (p_mask_and) else $error("irq not masked status");

  // ==========================================================================
  // Coverage
  c_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  c_ror: cover property (@(posedge pclk) disable iff (!presetn) $rose(s_q.latch[0]));
  c_clear: cover property (@(posedge pclk) disable iff (!presetn)
    s_q.latch[1] ##1 !s_q.latch[1]);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  c_read: cover property (@(posedge pclk) disable iff (!presetn)
    rd && paddr == SPIS_OFF_MIS ##1 prdata[0]);
endmodule // spis_irq

// File: spis_tb.sv
/*
  Self-checking testbench for the serial port interrupt status and clear block.
  Assumes spis_pkg and spis_irq are compiled first; the bench is the APB master
  and drives the serial engine source inputs itself.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  import spis_pkg::*;
  // ==========================================================================
  // Signals and model state
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic        tx_half_empty, rx_half_full, rx_timeout_evt, rx_overrun_evt;
  logic [1:0]  lv, lt;
  logic [3:0]  m;
  logic [31:0] seed = 32'h72B741ED;
  int          n_fail, n_compared;
  // ==========================================================================
  // Design
  spis_irq dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_half_empty(tx_half_empty), .rx_half_full(rx_half_full),
    .rx_timeout_evt(rx_timeout_evt), .rx_overrun_evt(rx_overrun_evt), .irq(irq));
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [3:0] exp_mis();
    return {lv, lt} & m;
  endfunction
  task automatic end_of_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One APB transfer; e is the expected error flag, x skips that check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    `CHK(n, 1)
    if (e !== 1'bx) `CHK(pslverr, e)
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Levels follow r[3:2]; r[1:0] pulse the sticky events
  task automatic src(input logic [3:0] s);
    tx_half_empty  <= s[3];
    rx_half_full   <= s[2];
    rx_timeout_evt <= s[1];
    rx_overrun_evt <= s[0];
    lv = s[3:2];
    lt = lt | s[1:0];
    repeat (3) @(posedge pclk);
    rx_timeout_evt <= 1'b0;
    rx_overrun_evt <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask
  // ==========================================================================
  // Clock, watchdog and main sequence
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    end_of_test();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {tx_half_empty, rx_half_full, rx_timeout_evt, rx_overrun_evt} = 4'h0;
    n_fail = 0;
    n_compared = 0;
    lv = 2'h0;
    lt = SPIS_LATCH_RST;
    m = SPIS_MASK_RST;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, SPIS_OFF_MIS, 32'h0, 1'b0);
    `CHK(rd, SPIS_RDATA_RST)
    `CHK(irq, 1'b0)
    for (int i = 0; i < 24; i++) begin
      r = xs();
      src(r[3:0]);
      m = r[7:4];
      apb(1'b1, SPIS_OFF_MASK, {28'h0, m}, 1'b0);
      apb(1'b0, SPIS_OFF_MIS, 32'h0, 1'b0);
      `CHK(rd, {28'h0, exp_mis()})
      `CHK(irq, |exp_mis())
      apb(1'b0, SPIS_OFF_RAW, 32'h0, 1'b0);
      `CHK(rd, {28'h0, lv, lt})
      apb(1'b0, SPIS_OFF_MASK, 32'h0, 1'b0);
      `CHK(rd, {28'h0, m})
      apb(1'b1, SPIS_OFF_MIS, r, 1'b0);
      apb(1'b1, SPIS_OFF_ICR, {r[31:10], r[9:8]} & 32'h3, 1'b0);
      lt = lt & ~r[9:8];
      apb(1'b0, SPIS_OFF_MIS, 32'h0, 1'b0);
      `CHK(rd, {28'h0, exp_mis()})
      `CHK(irq, |exp_mis())
    end
    apb(1'b0, 12'h100, 32'h0, 1'b1);
    apb(1'b0, SPIS_OFF_ICR, 32'h0, 1'b0);
    `CHK(rd, 32'h0)
    end_of_test();
  end
endmodule // testbench
